//--- sms_map.svh
// Constants for the serial peripheral controller: widths, fields and reset values
`ifndef SMS_MAP_SVH
`define SMS_MAP_SVH
`define SMS_NCS        4
`define SMS_CS_W       2
`define SMS_DIV_W      8
`define SMS_BITS_W     4
`define SMS_DLY_W      8
`define SMS_DATA_W     16
`define SMS_WORD_W     32
`define SMS_FIFO_DEPTH 32
`define SMS_FINAL_BIT  24
`define SMS_CS_LSB     16
`define SMS_MIN_BITS   5'h08
`define SMS_MAX_FIELD  4'h8
`define SMS_SEL_IDLE   4'hf
`define SMS_STRAY_TGL  2'h2
`endif

//--- sms_pkg.sv
// Types shared by the serial peripheral controller
package sms_pkg;
   typedef enum logic [2:0] {SMS_IDLE, SMS_GAP, SMS_SHIFT, SMS_EXTRA, SMS_BCT} sms_state_t;
endpackage

//--- sms_top.sv
// Serial peripheral controller with as-built quirks, and its transmit FIFO
// Operation
// - Master, odd divisor other than 1, polarity 1, phase bit 0: one extra clock pulse.
// - Keep-select with divisor 1: the word after an idle gap on one slave is sent twice.
// - Fixed select, keep-select and DMA: a word with bit 24 set drops the select at idle.
// - Select config written before master mode makes the serial clock toggle early.
// - The DMA transfer size follows the width field of select 0 whatever select is used.
// - Divisor 1 with an odd width of 9 to 15 bits gives one extra clock pulse.
// - Disable is ignored in slave mode; software reads data then resets instead.
// - Disable during a transfer starts endless dummy transfers; disable only when idle.
// - Software reset keeps the enable bit, so a later enable does not raise the flags.
// - Keep-select idle past both delays: a new slave is selected with no change delay.
// - Polarity 1, phase bit 0: a slow select then a divisor 1 select gives an extra pulse.
`timescale 1ns/10ps
`include "sms_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Transmit FIFO with registered input ready
module sms_fifo #(
   parameter int WIDTH = `SMS_WORD_W,
   parameter int DEPTH = `SMS_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
      $error("sms_fifo DEPTH must be a power of two of at least 2");
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp_r;
   logic [AW:0]      rp_r;
   logic [AW:0]      cnt_nxt;
   logic             inReady_r;
   wire              push = inValid & inReady_r;
   wire              pop  = outReady & outValid;

   // Occupancy after this cycle decides next ready
   assign cnt_nxt  = (wp_r + (AW+1)'(push)) - (rp_r + (AW+1)'(pop));
   assign inReady  = inReady_r;
   assign outValid = wp_r != rp_r;
   assign outData  = mem[rp_r[AW-1:0]];

   // Storage
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r[AW-1:0]] <= inData;
      end
   end

   // Pointers, flushed by software reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r      <= '0;
         rp_r      <= '0;
         inReady_r <= 1'b0;
      end else if (flush) begin
         wp_r      <= '0;
         rp_r      <= '0;
         inReady_r <= 1'b1;
      end else begin
         wp_r      <= wp_r + (AW+1)'(push);
         rp_r      <= rp_r + (AW+1)'(pop);
         inReady_r <= cnt_nxt != (AW+1)'(DEPTH);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Controller top: master and slave engine
module sms_top #(
   parameter int DEPTH = `SMS_FIFO_DEPTH
) (
   input  wire logic                            clk,
   input  wire logic                            rst,
   input  wire logic                            enableCmd,
   input  wire logic                            disableCmd,
   input  wire logic                            swResetCmd,
   input  wire logic                            masterSelectBit,
   input  wire logic                            fixedSelect,
   input  wire logic [`SMS_CS_W-1:0]            fixedCs,
   input  wire logic                            dmaMode,
   input  wire logic [`SMS_DLY_W-1:0]           selectChangeDelay,
   input  wire logic                            cfgWrite,
   input  wire logic [`SMS_NCS*`SMS_DIV_W-1:0]  clockDivisor,
   input  wire logic [`SMS_NCS*`SMS_BITS_W-1:0] bitsField,
   input  wire logic [`SMS_NCS-1:0]             clockPolarity,
   input  wire logic [`SMS_NCS-1:0]             clockPhaseBit,
   input  wire logic [`SMS_NCS-1:0]             keepSelectAfterTransfer,
   input  wire logic [`SMS_NCS*`SMS_DLY_W-1:0]  betweenTransferDelay,
   input  wire logic [`SMS_WORD_W-1:0]          txWord,
   input  wire logic                            txValid,
   output logic                                 txReady,
   output logic      [`SMS_DATA_W-1:0]          rxData,
   output logic                                 rxValid,
   input  wire logic                            serialClockPinIn,
   output logic                                 serialClockPinOut,
   output logic                                 serialClockPinOe,
   input  wire logic                            mosiIn,
   output logic                                 mosiOut,
   output logic                                 mosiOe,
   input  wire logic                            misoIn,
   output logic                                 misoOut,
   output logic                                 misoOe,
   input  wire logic                            slaveSelectInN,
   output logic      [`SMS_NCS-1:0]             peripheralSelectLinesN,
   output logic                                 portEnableBit,
   output logic                                 txReadyFlag,
   output logic                                 transmitIdleStatus,
   output logic                                 dmaHalfword
);
   // Width field to bit count, fields above 8 clip to 16 bits
   function automatic logic [4:0] fBits(input logic [3:0] f);
      fBits = (f > `SMS_MAX_FIELD) ? 5'h10 : `SMS_MIN_BITS + {1'b0, f};
   endfunction
   // Left-align a word so its first bit sits in the top position
   function automatic logic [15:0] fAlign(input logic [15:0] d, input logic [4:0] b);
      fAlign = d << (5'h10 - b);
   endfunction

   sms_pkg::sms_state_t state_r;
   logic [3:0]  in1_r, in2_r;
   logic        sckD_r, selD_r;
   logic [1:0]  cs_r;
   logic [4:0]  curBits_r;
   logic [7:0]  curDiv_r, divCnt_r, delayCnt_r;
   logic        curPol_r, curPha_r, curKeep_r, final_r, extra_r, prevSlow_r;
   logic [5:0]  edgeCnt_r;
   logic [9:0]  idleCnt_r;
   logic [15:0] sh_r, rxSh_r;
   logic        selHeld_r, resend_r, dummy_r, armed_r, enable_r, earlyCfg_r;
   logic [1:0]  strayCnt_r;
   logic        sck_r, mosi_r, miso_r, rxValid_r, sckOe_r, misoOe_r;
   logic [3:0]  selN_r;
   logic [15:0] rxData_r;
   logic        txRdyF_r, txIdle_r, dmaHw_r;
   logic [31:0] fifoData;
   logic        fifoValid, fifoInReady;

   // Synchronised pins, first stage read only by the second
   wire sckS = in2_r[3];
   wire mosiS = in2_r[2];
   wire misoS = in2_r[1];
   wire selSN = in2_r[0];
   wire master = masterSelectBit;
   wire idle = state_r == sms_pkg::SMS_IDLE;

   // Parameters of the next transfer
   wire [1:0]  nxtCs = dummy_r ? cs_r : fixedSelect ? fixedCs : fifoData[`SMS_CS_LSB +: 2];
   wire [7:0]  nDiv = clockDivisor[{nxtCs, 3'h0} +: 8];
   wire [4:0]  nBits = fBits(bitsField[{nxtCs, 2'h0} +: 4]);
   wire        nPol = clockPolarity[nxtCs];
   wire        nPha = clockPhaseBit[nxtCs];
   wire        nKeep = keepSelectAfterTransfer[nxtCs];
   wire        nFinal = !dummy_r & fifoData[`SMS_FINAL_BIT];
   wire [15:0] nAl = dummy_r ? 16'h0000 : fAlign(fifoData[15:0], nBits);
   wire        nDiv1 = nDiv == 8'h01;
   wire        oddCfg = nPol & !nPha & nDiv[0] & !nDiv1;
   wire        oddBits = nDiv1 & nBits[0];
   wire        mixCfg = nPol & !nPha & nDiv1 & prevSlow_r;
   wire        extraN = oddCfg | oddBits | mixCfg;

   // Start, select change and load decisions
   wire       canStart = master & idle & (enable_r | dummy_r) & (fifoValid | dummy_r)
                         & strayCnt_r == 2'h0;
   wire       swap = selHeld_r & nxtCs != cs_r;
   wire [8:0] quietLim = {1'b0, betweenTransferDelay[{cs_r, 3'h0} +: 8]}
                         + {1'b0, selectChangeDelay};
   wire       bypass = {1'b0, idleCnt_r} > {2'h0, quietLim};
   wire       goGap = canStart & swap & !bypass;
   wire       gapDone = state_r == sms_pkg::SMS_GAP & delayCnt_r == 8'h00;
   wire       doLoad = (canStart & !goGap) | gapDone;
   wire       holdWord = nKeep & nDiv1 & selHeld_r & !swap & idleCnt_r != 10'h000
                         & !resend_r & !dummy_r;
   wire       tick = divCnt_r == 8'h00;
   wire [5:0] lastEdge = {curBits_r, 1'b0} - 6'h01;
   wire       relSel = !curKeep_r | (final_r & (!fixedSelect | dmaMode));

   // Slave side uses select 0 settings
   wire [4:0] sBits = fBits(bitsField[3:0]);
   wire       sPha = clockPhaseBit[0];
   wire       sckEdge = sckS ^ sckD_r;
   wire       sActive = !master & enable_r & !selSN;
   wire       sEnd = sActive & sckEdge & edgeCnt_r == {sBits, 1'b0} - 6'h01;
   wire       sLoad = sActive & (selD_r | sEnd);
   wire [15:0] sAl = fifoValid ? fAlign(fifoData[15:0], sBits) : 16'h0000;
   wire       fifoPop = (doLoad & !dummy_r & !holdWord) | (sLoad & fifoValid);

   assign txReady = fifoInReady;
   assign rxData = rxData_r;
   assign rxValid = rxValid_r;
   assign serialClockPinOut = sck_r;
   assign serialClockPinOe = sckOe_r;
   assign mosiOut = mosi_r;
   assign mosiOe = sckOe_r;
   assign misoOut = miso_r;
   assign misoOe = misoOe_r;
   assign peripheralSelectLinesN = selN_r;
   assign portEnableBit = enable_r;
   assign txReadyFlag = txRdyF_r;
   assign transmitIdleStatus = txIdle_r;
   assign dmaHalfword = dmaHw_r;

   sms_fifo #(.WIDTH(`SMS_WORD_W), .DEPTH(DEPTH)) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .flush    (swResetCmd),
      .inData   (txWord),
      .inValid  (txValid),
      .inReady  (fifoInReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and edge history
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in1_r  <= 4'h1;
         in2_r  <= 4'h1;
         sckD_r <= 1'b0;
         selD_r <= 1'b1;
      end else begin
         in1_r  <= {serialClockPinIn, mosiIn, misoIn, slaveSelectInN};
         in2_r  <= in1_r;
         sckD_r <= sckS;
         selD_r <= selSN;
      end
   end

   // Status flags, pad enables, transfer size and early clock toggle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txRdyF_r   <= 1'b0;
         txIdle_r   <= 1'b0;
         dmaHw_r    <= 1'b0;
         sckOe_r    <= 1'b0;
         misoOe_r   <= 1'b0;
         earlyCfg_r <= 1'b0;
         strayCnt_r <= 2'h0;
      end else begin
         txRdyF_r <= armed_r & !swResetCmd & fifoInReady;
         txIdle_r <= armed_r & !swResetCmd & !fifoValid & idle & !dummy_r;
         dmaHw_r  <= fBits(bitsField[3:0]) > `SMS_MIN_BITS;
         sckOe_r  <= master & (enable_r | dummy_r);
         misoOe_r <= sActive;
         if (cfgWrite & !master) begin
            earlyCfg_r <= 1'b1;
         end else if (earlyCfg_r & master & enable_r & idle) begin
            earlyCfg_r <= 1'b0;
            strayCnt_r <= `SMS_STRAY_TGL;
         end else if (strayCnt_r != 2'h0) begin
            strayCnt_r <= strayCnt_r - 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transfer engine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= sms_pkg::SMS_IDLE;
         {cs_r, curBits_r, curDiv_r, divCnt_r, delayCnt_r} <= '0;
         {curPol_r, curPha_r, curKeep_r, final_r, extra_r, prevSlow_r} <= '0;
         {edgeCnt_r, idleCnt_r, sh_r, rxSh_r, rxData_r} <= '0;
         {selHeld_r, resend_r, dummy_r, armed_r, enable_r} <= '0;
         {sck_r, mosi_r, miso_r, rxValid_r} <= '0;
         selN_r <= `SMS_SEL_IDLE;
      end else if (swResetCmd) begin
         state_r   <= sms_pkg::SMS_IDLE;                          // enable kept
         armed_r   <= 1'b0;
         dummy_r   <= 1'b0;
         selHeld_r <= 1'b0;
         resend_r  <= 1'b0;
         rxValid_r <= 1'b0;
         edgeCnt_r <= 6'h00;
         selN_r    <= `SMS_SEL_IDLE;
      end else begin
         rxValid_r <= 1'b0;
         if (enableCmd & !enable_r) begin
            enable_r <= 1'b1;
            armed_r  <= 1'b1;
         end
         if (disableCmd & master) begin
            enable_r <= 1'b0;
            armed_r  <= 1'b0;
            if (!idle) begin
               dummy_r <= 1'b1;
            end
         end
         if (master) begin
            unique case (state_r)
               sms_pkg::SMS_IDLE: begin
                  sck_r <= (strayCnt_r != 2'h0) ? ~sck_r : (selHeld_r ? curPol_r : nPol);
                  if (selHeld_r && idleCnt_r != 10'h3ff) begin
                     idleCnt_r <= idleCnt_r + 10'h001;
                  end
                  if (goGap) begin
                     selN_r     <= `SMS_SEL_IDLE;
                     selHeld_r  <= 1'b0;
                     delayCnt_r <= selectChangeDelay;
                     state_r    <= sms_pkg::SMS_GAP;
                  end
               end
               sms_pkg::SMS_GAP: begin
                  delayCnt_r <= delayCnt_r - 8'h01;
               end
               sms_pkg::SMS_SHIFT, sms_pkg::SMS_EXTRA: begin
                  divCnt_r <= tick ? curDiv_r - 8'h01 : divCnt_r - 8'h01;
                  if (tick) begin
                     sck_r     <= ~sck_r;
                     edgeCnt_r <= edgeCnt_r + 6'h01;
                     if (state_r == sms_pkg::SMS_EXTRA) begin
                        if (edgeCnt_r == 6'h01) begin
                           state_r    <= sms_pkg::SMS_BCT;
                           delayCnt_r <= betweenTransferDelay[{cs_r, 3'h0} +: 8];
                        end
                     end else begin
                        if (edgeCnt_r[0] != curPha_r) begin
                           rxSh_r <= {rxSh_r[14:0], misoS};
                        end else begin
                           mosi_r <= sh_r[15];
                           sh_r   <= {sh_r[14:0], 1'b0};
                        end
                        if (edgeCnt_r == lastEdge) begin
                           edgeCnt_r  <= 6'h00;
                           state_r    <= extra_r ? sms_pkg::SMS_EXTRA : sms_pkg::SMS_BCT;
                           delayCnt_r <= betweenTransferDelay[{cs_r, 3'h0} +: 8];
                        end
                     end
                  end
               end
               sms_pkg::SMS_BCT: begin
                  delayCnt_r <= delayCnt_r - 8'h01;
                  if (delayCnt_r == 8'h00) begin
                     rxData_r  <= rxSh_r;
                     rxValid_r <= 1'b1;
                     state_r   <= sms_pkg::SMS_IDLE;
                     idleCnt_r <= 10'h000;
                     if (relSel) begin
                        selN_r    <= `SMS_SEL_IDLE;
                        selHeld_r <= 1'b0;
                     end
                  end
               end
            endcase
            // Load the next word into the shifter and select its slave
            if (doLoad) begin
               state_r    <= sms_pkg::SMS_SHIFT;
               cs_r       <= nxtCs;
               curBits_r  <= nBits;
               curDiv_r   <= nDiv;
               divCnt_r   <= nDiv - 8'h01;
               curPol_r   <= nPol;
               curPha_r   <= nPha;
               curKeep_r  <= nKeep;
               final_r    <= nFinal;
               extra_r    <= extraN;
               prevSlow_r <= !nDiv1;
               selN_r     <= ~(4'h1 << nxtCs);
               selHeld_r  <= 1'b1;
               idleCnt_r  <= 10'h000;
               edgeCnt_r  <= 6'h00;
               rxSh_r     <= 16'h0000;
               resend_r   <= holdWord;
               sck_r      <= nPol;
               mosi_r     <= nAl[15];
               sh_r       <= nPha ? {nAl[14:0], 1'b0} : nAl;
            end
         end else begin
            // Slave: count edges of the synchronised clock while selected
            selN_r <= `SMS_SEL_IDLE;
            state_r <= sms_pkg::SMS_IDLE;
            if (!sActive) begin
               edgeCnt_r <= 6'h00;
            end else if (sckEdge) begin
               edgeCnt_r <= sEnd ? 6'h00 : edgeCnt_r + 6'h01;
               if (edgeCnt_r[0] != sPha) begin
                  rxSh_r <= {rxSh_r[14:0], mosiS};
               end else begin
                  miso_r <= sh_r[15];
                  sh_r   <= {sh_r[14:0], 1'b0};
               end
               if (sEnd) begin
                  rxData_r  <= (edgeCnt_r[0] != sPha) ? {rxSh_r[14:0], mosiS} : rxSh_r;
                  rxValid_r <= 1'b1;
               end
            end
            if (sLoad) begin
               miso_r <= sAl[15];
               sh_r   <= sPha ? {sAl[14:0], 1'b0} : sAl;
            end
         end
      end
   end
endmodule

//--- sms_properties.sv
// Port-level assertions for the serial controller
`timescale 1ns/10ps
`include "sms_map.svh"
module sms_properties #(
   parameter int DEPTH = `SMS_FIFO_DEPTH
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        enableCmd,
   input wire logic        disableCmd,
   input wire logic        swResetCmd,
   input wire logic        masterSelectBit,
   input wire logic [15:0] bitsField,
   input wire logic        rxValid,
   input wire logic        serialClockPinOe,
   input wire logic        mosiOe,
   input wire logic        misoOe,
   input wire logic [3:0]  peripheralSelectLinesN,
   input wire logic        portEnableBit,
   input wire logic        txReadyFlag,
   input wire logic        transmitIdleStatus,
   input wire logic        dmaHalfword
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Transfer size always follows select 0 width
   dma_size_a : assert property (
      $stable(bitsField[3:0]) && !$past(rst) |-> dmaHalfword == (bitsField[3:0] != 4'h0))
      else $error("transfer size does not follow select 0 width");
   // At most one select line active
   one_select_a : assert property ($countones(~peripheralSelectLinesN) <= 1)
      else $error("more than one select line low");
   // Disable is ignored in slave mode
   slave_disable_a : assert property (
      disableCmd && !masterSelectBit |=> portEnableBit == $past(portEnableBit))
      else $error("disable acted in slave mode");
   // Software reset keeps enable, clears flags and selects
   sw_reset_a : assert property (
      swResetCmd |=> $stable(portEnableBit) && !txReadyFlag && !transmitIdleStatus
      && peripheralSelectLinesN == 4'hf)
      else $error("software reset effects wrong");
   // Enable from disabled sets the enable bit
   enable_set_a : assert property (enableCmd && !portEnableBit |=> portEnableBit)
      else $error("enable did not set the enable bit");
   // Enabled master drives clock and data
   oe_pair_a : assert property (
      $past(masterSelectBit) && $past(portEnableBit) |-> serialClockPinOe && mosiOe)
      else $error("clock or data not driven by enabled master");
   // Master mode does not drive the slave output after its first cycle
   miso_oe_a : assert property (
      masterSelectBit && $past(masterSelectBit) && $past(masterSelectBit, 2) |-> !misoOe)
      else $error("slave output driven in master mode");
   // Receive strobe lasts one cycle
   rx_pulse_a : assert property (rxValid |=> !rxValid)
      else $error("receive strobe longer than one cycle");
endmodule

bind sms_top sms_properties #(.DEPTH(DEPTH)) chk (.*);

//--- sms_slave_model.sv
// Behavioural serial slave sitting on the shared select lines
`timescale 1ns/10ps
module sms_slave_model #(
   parameter logic [15:0] PAT = 16'ha5c3
) (
   input  wire logic        sck,
   input  wire logic [3:0]  selN,
   input  wire logic        mosi,
   output logic             miso,
   output logic      [15:0] got
);
   logic [3:0] idx;

   initial begin
      miso = 1'b0;
      idx = 4'h0;
      got = 16'h0000;
   end
   // Reply starts on select; released line shows the inverse of its last level
   always @(selN) begin
      idx = 4'h0;
      miso = (selN == 4'hf) ? ~miso : PAT[15];
   end
   // Sample on the rising edge, move the reply on the falling edge
   always @(posedge sck) if (selN != 4'hf) got <= {got[14:0], mosi};
   always @(negedge sck) if (selN != 4'hf) begin
      idx = idx + 4'h1;
      miso = PAT[~idx];
   end
endmodule

//--- tb.sv
// Self-checking bench for the serial controller
`timescale 1ns/10ps
`include "sms_map.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin num_errors++; \
   $display("BAD %s exp %0h seen %0h", n, e, s); end end
module tb;
   logic        clk, rst, enableCmd, disableCmd, swResetCmd, cfgWrite, masterSelectBit;
   logic        fixedSelect, dmaMode, txValid, txReady, rxValid, serialClockPinIn, mosiIn;
   logic        misoIn, slaveSelectInN, serialClockPinOut, mosiOut, portEnableBit;
   logic        txReadyFlag, transmitIdleStatus, dmaHalfword, misoOut;
   logic [1:0]  fixedCs;
   logic [7:0]  selectChangeDelay;
   logic [3:0]  clockPolarity, clockPhaseBit, keepSelectAfterTransfer, peripheralSelectLinesN;
   logic [15:0] bitsField, rxData, got;
   logic [31:0] clockDivisor, betweenTransferDelay, txWord;
   logic [15:0] rows [9] = '{16'h0401, 16'h0302, 16'h0303, 16'h0300, 16'h0202,
                             16'h0111, 16'h0121, 16'h0171, 16'h0181};
   int          check_count, num_errors, selT, idleT, nIdle, rxCnt, t0, n;
   logic        sckP;
   logic [3:0]  selP;

   sms_top #(.DEPTH(8)) DUT (.*, .serialClockPinOe(), .mosiOe(), .misoOe());
   sms_slave_model SLV (.sck(serialClockPinOut), .selN(peripheralSelectLinesN), .mosi(mosiOut),
                        .miso(misoIn), .got(got));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Count clock toggles inside and outside frames, idle cycles and strobes
   always @(posedge clk) begin
      sckP <= serialClockPinOut;
      selP <= peripheralSelectLinesN;
      if (serialClockPinOut !== sckP && peripheralSelectLinesN != 4'hf && selP != 4'hf) selT++;
      if (!rst && serialClockPinOut !== sckP && peripheralSelectLinesN == 4'hf) idleT++;
      if (peripheralSelectLinesN == 4'hf) nIdle++;
      if (rxValid === 1'b1) rxCnt++;
   end
   initial begin
      #2_000_000;
      num_errors++;
      tally_and_finish;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task cyc(input int k); repeat (k) @(posedge clk); endtask
   // Pulse {cfgWrite, swResetCmd, disableCmd, enableCmd}
   task cmd(input logic [3:0] m);
      {cfgWrite, swResetCmd, disableCmd, enableCmd} <= m;
      cyc(1);
      {cfgWrite, swResetCmd, disableCmd, enableCmd} <= 4'h0;
      cyc(2);
   endtask
   task push(input logic [31:0] w);
      int k;
      k = 0;
      txWord <= w;
      txValid <= 1'b1;
      do begin cyc(1); k++; end while (txReady !== 1'b1 && k < 500);
      txValid <= 1'b0;
      cyc(1);
   endtask
   task waitRx(input int lim);
      int k;
      k = 0;
      while (rxValid !== 1'b1 && k < lim) begin cyc(1); k++; end
      `CHK("rxValid", 1'b1, rxValid)
   endtask
   task xfer(input logic [31:0] w, input int e);
      int s0;
      s0 = selT;
      push(w);
      waitRx(3000);
      cyc(4);
      `CHK("toggles", e, selT - s0)
   endtask
   task slaveRx(input logic [7:0] d);
      #37 slaveSelectInN = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosiIn = d[i];
         #400 serialClockPinIn = 1'b1;
         #400 serialClockPinIn = 1'b0;
      end
      #400 slaveSelectInN = 1'b1;
   endtask
   function int expT(int d, int b, bit p, bit h);
      return 2 * b + (((p && !h && d % 2 && d != 1) || (d == 1 && b % 2)) ? 2 : 0);
   endfunction
   task tally_and_finish;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {enableCmd, disableCmd, swResetCmd, cfgWrite, txValid, masterSelectBit} = 6'h00;
      {fixedSelect, dmaMode, fixedCs, txWord, bitsField} = '0;
      {serialClockPinIn, mosiIn, slaveSelectInN} = 3'h1;
      {clockPolarity, clockPhaseBit, keepSelectAfterTransfer} = 12'h0f0;
      clockDivisor = 32'h0404_0404;
      betweenTransferDelay = 32'h0202_0202;
      selectChangeDelay = 8'h04;
      cyc(16);
      rst <= 1'b0;
      cyc(2);
      cmd(4'h8);
      cmd(4'h1);
      cmd(4'h2);
      `CHK("enable", 1'b1, portEnableBit)
      fork slaveRx(8'h5a); waitRx(200); join
      `CHK("slaveRx", 8'h5a, rxData[7:0])
      `CHK("misoOut", 1'b0, misoOut)
      masterSelectBit <= 1'b1;
      cyc(20);
      `CHK("stray", 2, idleT)
      cmd(4'h4);
      cmd(4'h1);
      `CHK("keptEn", 1'b1, portEnableBit)
      `CHK("noReady", 1'b0, txReadyFlag)
      cmd(4'h2);
      cmd(4'h1);
      `CHK("ready", 2'h3, {txReadyFlag, transmitIdleStatus})
      foreach (rows[i]) begin
         clockDivisor[7:0] <= rows[i][15:8];
         bitsField[3:0] <= rows[i][7:4];
         {clockPolarity[0], clockPhaseBit[0]} <= rows[i][1:0];
         cyc(2);
         n = expT(rows[i][15:8], 8 + rows[i][7:4], rows[i][1], rows[i][0]);
         xfer(32'h0000_0096, n);
         if (i == 0) `CHK("mosi", 8'h96, got[7:0])
         if (i == 0) `CHK("miso", 8'ha5, rxData[7:0])
      end
      clockDivisor[15:0] <= 16'h0401;
      bitsField <= 16'h0000;
      clockPolarity <= 4'h3;
      clockPhaseBit <= 4'h0;
      cyc(2);
      xfer(32'h0000_9600, 16);
      xfer(32'h0001_9600, 16);
      xfer(32'h0000_9600, 18);
      {clockDivisor[7:0], clockPolarity, clockPhaseBit} <= 16'h040f;
      keepSelectAfterTransfer <= 4'h6;
      selectChangeDelay <= 8'h14;
      push(32'h0001_9600);
      waitRx(3000);
      cyc(40);
      t0 = nIdle;
      push(32'h0002_9600);
      waitRx(3000);
      `CHK("noGap", 0, nIdle - t0)
      {fixedSelect, dmaMode, fixedCs, bitsField} <= {4'he, 16'h0002};
      cyc(2);
      `CHK("half", 1'b1, dmaHalfword)
      bitsField <= 16'h0200;
      cyc(2);
      `CHK("byte", 1'b0, dmaHalfword)
      push(32'h0000_9600);
      waitRx(3000);
      cyc(10);
      `CHK("held", 4'hb, peripheralSelectLinesN)
      push(32'h0100_9600);
      waitRx(3000);
      cyc(10);
      `CHK("final", 4'hf, peripheralSelectLinesN)
      {fixedSelect, dmaMode, bitsField, clockDivisor[7:0]} <= {18'h0, 8'h01};
      keepSelectAfterTransfer <= 4'h1;
      push(32'h0000_9600);
      waitRx(3000);
      cyc(20);
      t0 = rxCnt;
      push(32'h0000_6900);
      cyc(300);
      `CHK("twice", 2, rxCnt - t0)
      {keepSelectAfterTransfer, clockDivisor[7:0]} <= 12'h004;
      push(32'h0000_9600);
      cyc(6);
      cmd(4'h2);
      t0 = rxCnt;
      cyc(600);
      `CHK("dummies", 1'b1, rxCnt - t0 > 3)
      cmd(4'h4);
      `CHK("released", 4'hf, peripheralSelectLinesN)
      cmd(4'h2);
      n = 0;
      txValid <= 1'b1;
      repeat (12) begin cyc(1); if (txReady === 1'b1) n++; end
      txValid <= 1'b0;
      `CHK("filled", 8, n)
      t0 = rxCnt;
      cmd(4'h1);
      cyc(1500);
      `CHK("drained", 8, rxCnt - t0)
      `CHK("space", 1'b1, txReady)
      tally_and_finish;
   end
endmodule
